// >>> rtl/txe_pkg.sv
`default_nettype none
package txe_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int TXE_CHANNELS = 12;
	localparam int TXE_CH_IDX_W = 4;
	localparam int TXE_ADDR_W = 8;
	localparam int TXE_DATA_W = 32;
	localparam int TXE_FIFO_W = 6;
	localparam int TXE_FIFO_D = 8;
	localparam int TXE_DROP_W = 16;
	localparam int TXE_PRBS_W = 15;
	localparam int TXE_RATE_W = 2;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] TXE_OFS_TX_ENABLE = 8'h00;
	localparam logic [7:0] TXE_OFS_RAIL_MODE = 8'h04;
	localparam logic [7:0] TXE_OFS_RATE_SEL = 8'h08;
	localparam logic [7:0] TXE_OFS_PRBS_EN = 8'h0c;
	localparam logic [7:0] TXE_OFS_STATUS = 8'h10;
	localparam logic [7:0] TXE_OFS_MON_SEL = 8'h14;
	localparam logic [7:0] TXE_OFS_MON_DATA = 8'h18;
	localparam logic [7:0] TXE_OFS_DROP_CNT = 8'h1c;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int TXE_STAT_PIN_BIT = 12;
	localparam int TXE_MON_VALID_BIT = 31;
	localparam logic [11:0] TXE_RST_TX_ENABLE = 12'hfff;
	localparam logic [11:0] TXE_RST_RAIL_MODE = 12'h000;
	localparam logic [23:0] TXE_RST_RATE_SEL = 24'h000000;
	localparam logic [11:0] TXE_RST_PRBS_EN = 12'h000;
	localparam logic [3:0] TXE_RST_MON_SEL = 4'h0;
	localparam logic [14:0] TXE_PRBS_SEED = 15'h7fff;
	localparam logic TXE_RST_PIN_LEVEL = 1'b1;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TXE_RATE_DS3 = 2'h0,
		TXE_RATE_E3 = 2'h1,
		TXE_RATE_STS1 = 2'h2
	} txe_rate_t;

	typedef enum logic [1:0] {
		TXE_SYM_ZERO,
		TXE_SYM_MARK,
		TXE_SYM_VIOL,
		TXE_SYM_BIP
	} txe_sym_t;

endpackage : txe_pkg
`default_nettype wire

// >>> rtl/txe_fifo_if.sv
`default_nettype none
interface txe_fifo_if #(parameter int W = txe_pkg::TXE_FIFO_W);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;

	// Storage side
	modport store (input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data);
	// Producer and consumer side
	modport user (output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data);
endinterface : txe_fifo_if
`default_nettype wire

// >>> rtl/txe_fifo.sv
`default_nettype none
module txe_fifo #(
	parameter int W = txe_pkg::TXE_FIFO_W,
	parameter int DEPTH = txe_pkg::TXE_FIFO_D
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_enable,
	txe_fifo_if.store f
);
	import txe_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	logic [W-1:0] out_data_r;
	logic out_valid_r;
	logic push;
	logic load;

	// ------------------------------------------------------------
	// Handshake
	// ------------------------------------------------------------
	// The output register holds a word too, so it counts toward the depth
	assign f.in_ready = (CNT_W'(count_r + CNT_W'(out_valid_r)) != FULL_CNT);
	assign push = f.in_valid && f.in_ready && clock_enable;
	assign load = (count_r != '0) && (!out_valid_r || f.out_ready) && clock_enable;
	assign f.out_valid = out_valid_r;
	assign f.out_data = out_data_r;

	// Array write
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_ptr_r] <= f.in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= PTR_W'(wr_ptr_r + 1'b1);
			end
			if (load) begin
				rd_ptr_r <= PTR_W'(rd_ptr_r + 1'b1);
			end
			if (push && !load) begin
				count_r <= CNT_W'(count_r + 1'b1);
			end else if (load && !push) begin
				count_r <= CNT_W'(count_r - 1'b1);
			end
		end
	end

	// Registered read port, refilled whenever the consumer takes a word and the array still holds one
	always_ff @(posedge clock) begin
		if (rst) begin
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else if (clock_enable) begin
			if (load) begin
				out_data_r <= mem_r[rd_ptr_r];
				out_valid_r <= 1'b1;
			end else if (f.out_ready) begin
				out_valid_r <= 1'b0;
			end
		end
	end

endmodule : txe_fifo
`default_nettype wire

// >>> rtl/txe_tx_input_encoder.sv
`default_nettype none
module txe_tx_input_encoder (
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_enable,
	input wire logic [txe_pkg::TXE_ADDR_W-1:0] reg_addr,
	input wire logic [txe_pkg::TXE_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [txe_pkg::TXE_DATA_W-1:0] reg_rdata,
	input wire logic transmit_power_enable,
	input wire logic [txe_pkg::TXE_CHANNELS-1:0] channel_transmit_clock,
	input wire logic [txe_pkg::TXE_CHANNELS-1:0] transmit_positive_data,
	input wire logic [txe_pkg::TXE_CHANNELS-1:0] transmit_negative_data,
	output logic [txe_pkg::TXE_CHANNELS-1:0] line_output_positive,
	output logic [txe_pkg::TXE_CHANNELS-1:0] line_output_negative,
	output logic [txe_pkg::TXE_CHANNELS-1:0] line_output_enable_n,
	output logic [txe_pkg::TXE_CHANNELS-1:0] transmitter_powered
);
	import txe_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [TXE_CHANNELS-1:0] tx_enable_r;
	logic [TXE_CHANNELS-1:0] rail_dual_r;
	logic [2*TXE_CHANNELS-1:0] rate_sel_r;
	logic [TXE_CHANNELS-1:0] prbs_en_r;
	logic [TXE_CH_IDX_W-1:0] mon_sel_r;
	logic [TXE_DROP_W-1:0] drop_cnt_r;
	logic [TXE_DATA_W-1:0] rdata_r;
	logic pwr_s1_r;
	logic pwr_s2_r;
	logic pwr_s3_r;
	logic pwr_lvl_r;
	logic [TXE_CHANNELS-1:0] powered;
	logic [TXE_CHANNELS-1:0] ch_edge;
	logic [TXE_CHANNELS-1:0] ch_pos;
	logic [TXE_CHANNELS-1:0] ch_neg;
	logic mon_push_r;
	logic [TXE_FIFO_W-1:0] mon_data;
	logic mon_pop;

	txe_fifo_if #(.W(TXE_FIFO_W)) mon_f ();

	// ------------------------------------------------------------
	// Bus and rate decode helpers
	// ------------------------------------------------------------
	function automatic logic addr_hit(input logic [TXE_ADDR_W-1:0] addr, input logic [TXE_ADDR_W-1:0] ofs);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

	function automatic logic uses_hdb3(input logic [TXE_RATE_W-1:0] rate);
		uses_hdb3 = (rate == TXE_RATE_E3);
	endfunction : uses_hdb3

	// ------------------------------------------------------------
	// Global power pin
	// ------------------------------------------------------------
	// Filtered level starts high, matching the internal pull-up
	always_ff @(posedge clock) begin
		if (rst) begin
			pwr_s1_r <= TXE_RST_PIN_LEVEL;
			pwr_s2_r <= TXE_RST_PIN_LEVEL;
			pwr_s3_r <= TXE_RST_PIN_LEVEL;
			pwr_lvl_r <= TXE_RST_PIN_LEVEL;
		end else if (clock_enable) begin
			pwr_s1_r <= transmit_power_enable;
			pwr_s2_r <= pwr_s1_r;
			pwr_s3_r <= pwr_s2_r;
			if (pwr_s2_r == pwr_s3_r) begin
				pwr_lvl_r <= pwr_s3_r;
			end
		end
	end

	// Pin low overrides every channel bit; pin high hands control to software
	assign powered = pwr_lvl_r ? tx_enable_r : '0;
	assign transmitter_powered = powered;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// All channels enabled out of reset so the line comes up driven
	always_ff @(posedge clock) begin
		if (rst) begin
			tx_enable_r <= TXE_RST_TX_ENABLE;
			rail_dual_r <= TXE_RST_RAIL_MODE;
			rate_sel_r <= TXE_RST_RATE_SEL;
			prbs_en_r <= TXE_RST_PRBS_EN;
			mon_sel_r <= TXE_RST_MON_SEL;
		end else if (clock_enable && reg_write) begin
			if (addr_hit(reg_addr, TXE_OFS_TX_ENABLE)) begin
				tx_enable_r <= reg_wdata[TXE_CHANNELS-1:0];
			end
			if (addr_hit(reg_addr, TXE_OFS_RAIL_MODE)) begin
				rail_dual_r <= reg_wdata[TXE_CHANNELS-1:0];
			end
			if (addr_hit(reg_addr, TXE_OFS_RATE_SEL)) begin
				rate_sel_r <= reg_wdata[2*TXE_CHANNELS-1:0];
			end
			if (addr_hit(reg_addr, TXE_OFS_PRBS_EN)) begin
				prbs_en_r <= reg_wdata[TXE_CHANNELS-1:0];
			end
			if (addr_hit(reg_addr, TXE_OFS_MON_SEL)) begin
				mon_sel_r <= reg_wdata[TXE_CH_IDX_W-1:0];
			end
		end
	end

	// Read data stand for exactly the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_r <= '0;
		end else if (clock_enable) begin
			rdata_r <= '0;
			if (reg_read) begin
				if (addr_hit(reg_addr, TXE_OFS_TX_ENABLE)) begin
					rdata_r <= {20'h00000, tx_enable_r};
				end else if (addr_hit(reg_addr, TXE_OFS_RAIL_MODE)) begin
					rdata_r <= {20'h00000, rail_dual_r};
				end else if (addr_hit(reg_addr, TXE_OFS_RATE_SEL)) begin
					rdata_r <= {8'h00, rate_sel_r};
				end else if (addr_hit(reg_addr, TXE_OFS_PRBS_EN)) begin
					rdata_r <= {20'h00000, prbs_en_r};
				end else if (addr_hit(reg_addr, TXE_OFS_STATUS)) begin
					rdata_r <= {19'h00000, pwr_lvl_r, powered};
				end else if (addr_hit(reg_addr, TXE_OFS_MON_SEL)) begin
					rdata_r <= {28'h0000000, mon_sel_r};
				end else if (addr_hit(reg_addr, TXE_OFS_MON_DATA)) begin
					rdata_r <= mon_f.out_valid ? {1'b1, 25'h0000000, mon_f.out_data} : '0; // Empty reads as zero
				end else if (addr_hit(reg_addr, TXE_OFS_DROP_CNT)) begin
					rdata_r <= {16'h0000, drop_cnt_r};
				end
			end
		end
	end
	assign reg_rdata = rdata_r;

	// ------------------------------------------------------------
	// Per-channel transmit section
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < TXE_CHANNELS; ch++) begin : g_ch
			logic clk_s1_r;
			logic clk_s2_r;
			logic clk_s3_r;
			logic clk_lvl_r;
			logic pos_s1_r;
			logic pos_s2_r;
			logic pos_s3_r;
			logic pos_lvl_r;
			logic neg_s1_r;
			logic neg_s2_r;
			logic neg_s3_r;
			logic neg_lvl_r;
			logic [TXE_PRBS_W-1:0] prbs_r;
			txe_sym_t sr_r [4];
			txe_sym_t sr_nxt [4];
			logic par_r;
			logic par_nxt;
			logic last_pos_r;
			logic pos_out_r;
			logic neg_out_r;
			logic oe_n_r;
			logic edge_hit;
			logic bit_in;
			logic hdb3;

			// Clock and both rails share one sampler so they stay aligned
			always_ff @(posedge clock) begin
				if (rst) begin
					{clk_s1_r, clk_s2_r, clk_s3_r, clk_lvl_r} <= 4'h0;
					{pos_s1_r, pos_s2_r, pos_s3_r, pos_lvl_r} <= 4'h0;
					{neg_s1_r, neg_s2_r, neg_s3_r, neg_lvl_r} <= 4'h0;
				end else if (clock_enable) begin
					clk_s1_r <= channel_transmit_clock[ch];
					clk_s2_r <= clk_s1_r;
					clk_s3_r <= clk_s2_r;
					pos_s1_r <= transmit_positive_data[ch];
					pos_s2_r <= pos_s1_r;
					pos_s3_r <= pos_s2_r;
					neg_s1_r <= transmit_negative_data[ch];
					neg_s2_r <= neg_s1_r;
					neg_s3_r <= neg_s2_r;
					if (clk_s2_r == clk_s3_r) begin
						clk_lvl_r <= clk_s3_r;
					end
					if (pos_s2_r == pos_s3_r) begin
						pos_lvl_r <= pos_s3_r;
					end
					if (neg_s2_r == neg_s3_r) begin
						neg_lvl_r <= neg_s3_r;
					end
				end
			end

			// Rising edge of the filtered clock; rail levels still hold pre-edge values
			assign edge_hit = clock_enable && (clk_s2_r == clk_s3_r) && clk_s3_r && !clk_lvl_r;
			assign hdb3 = uses_hdb3(rate_sel_r[TXE_RATE_W*ch +: TXE_RATE_W]);
			assign bit_in = prbs_en_r[ch] ? prbs_r[TXE_PRBS_W-1] : pos_lvl_r;

			// Pattern source for test, x^15 + x^14 + 1
			always_ff @(posedge clock) begin
				if (rst) begin
					prbs_r <= TXE_PRBS_SEED;
				end else if (edge_hit) begin
					prbs_r <= {prbs_r[TXE_PRBS_W-2:0], prbs_r[14] ^ prbs_r[13]};
				end
			end

			// Zero-run look-ahead: four symbols of delay make room for either code
			always_comb begin
				sr_nxt[3] = sr_r[2];
				sr_nxt[2] = sr_r[1];
				sr_nxt[1] = sr_r[0];
				sr_nxt[0] = bit_in ? TXE_SYM_MARK : TXE_SYM_ZERO;
				par_nxt = bit_in ? !par_r : par_r;
				if (hdb3 && !bit_in && sr_r[0] == TXE_SYM_ZERO && sr_r[1] == TXE_SYM_ZERO
					&& sr_r[2] == TXE_SYM_ZERO) begin
					sr_nxt[0] = TXE_SYM_VIOL;
					sr_nxt[3] = par_r ? TXE_SYM_ZERO : TXE_SYM_BIP;
					par_nxt = 1'b0;
				end else if (!hdb3 && !bit_in && sr_r[0] == TXE_SYM_ZERO && sr_r[1] == TXE_SYM_ZERO) begin
					sr_nxt[0] = TXE_SYM_VIOL;
					sr_nxt[2] = par_r ? TXE_SYM_ZERO : TXE_SYM_BIP;
					par_nxt = 1'b0;
				end
			end

			// Symbol pipeline and substitution parity
			always_ff @(posedge clock) begin
				if (rst) begin
					sr_r <= '{default: TXE_SYM_ZERO};
					par_r <= 1'b0;
				end else if (edge_hit) begin
					sr_r <= sr_nxt;
					par_r <= par_nxt;
				end
			end

			// Line symbol: alternate marks, violations repeat the last polarity
			always_ff @(posedge clock) begin
				if (rst) begin
					pos_out_r <= 1'b0;
					neg_out_r <= 1'b0;
					last_pos_r <= 1'b0;
					oe_n_r <= 1'b1;
				end else if (clock_enable) begin
					oe_n_r <= !powered[ch];
					if (!powered[ch]) begin
						pos_out_r <= 1'b0;
						neg_out_r <= 1'b0;
					end else if (edge_hit && rail_dual_r[ch]) begin
						pos_out_r <= pos_lvl_r;
						neg_out_r <= neg_lvl_r;
					end else if (edge_hit) begin
						// Negative rail unused here; a stray level cannot leak out
						case (sr_r[3])
							TXE_SYM_MARK, TXE_SYM_BIP: begin
								pos_out_r <= !last_pos_r;
								neg_out_r <= last_pos_r;
								last_pos_r <= !last_pos_r;
							end
							TXE_SYM_VIOL: begin
								pos_out_r <= last_pos_r;
								neg_out_r <= !last_pos_r;
							end
							default: begin
								pos_out_r <= 1'b0;
								neg_out_r <= 1'b0;
							end
						endcase
					end
				end
			end

			assign line_output_positive[ch] = pos_out_r;
			assign line_output_negative[ch] = neg_out_r;
			assign line_output_enable_n[ch] = oe_n_r;
			assign ch_edge[ch] = edge_hit;
			assign ch_pos[ch] = pos_out_r;
			assign ch_neg[ch] = neg_out_r;
		end
	endgenerate

	// ------------------------------------------------------------
	// Line monitor buffer
	// ------------------------------------------------------------
	// Push one cycle after the edge, once the output flops hold the symbol
	always_ff @(posedge clock) begin
		if (rst) begin
			mon_push_r <= 1'b0;
		end else if (clock_enable) begin
			mon_push_r <= (mon_sel_r < TXE_CH_IDX_W'(TXE_CHANNELS)) && ch_edge[mon_sel_r];
		end
	end

	assign mon_data = {mon_sel_r, ch_pos[mon_sel_r], ch_neg[mon_sel_r]};
	assign mon_pop = clock_enable && reg_read && addr_hit(reg_addr, TXE_OFS_MON_DATA);
	assign mon_f.in_valid = mon_push_r;
	assign mon_f.in_data = mon_data;
	assign mon_f.out_ready = mon_pop;

	// The line cannot wait, so a full buffer loses symbols and counts them
	always_ff @(posedge clock) begin
		if (rst) begin
			drop_cnt_r <= '0;
		end else if (clock_enable && mon_push_r && !mon_f.in_ready && drop_cnt_r != 16'hffff) begin
			drop_cnt_r <= TXE_DROP_W'(drop_cnt_r + 1'b1);
		end
	end

	txe_fifo #(.W(TXE_FIFO_W), .DEPTH(TXE_FIFO_D)) u_mon_fifo (
		.clock(clock),
		.rst(rst),
		.clock_enable(clock_enable),
		.f(mon_f)
	);

endmodule : txe_tx_input_encoder
`default_nettype wire

// >>> sim/txe_input_properties.sv
`default_nettype none
module txe_input_properties (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic transmit_power_enable,
	input wire logic [11:0] channel_transmit_clock,
	input wire logic [11:0] line_output_positive,
	input wire logic [11:0] line_output_negative,
	input wire logic [11:0] line_output_enable_n,
	input wire logic [11:0] transmitter_powered
);
	import txe_pkg::*;
	// ------------------------------------------------------------
	// Power, line output and read data checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Reset brings every transmitter up
	property p_up;
		$fell(rst) |-> transmitter_powered == 12'hfff;
	endproperty
	a_up: assert property (p_up) else $error("not all on after reset");
	// Pin filter needs several samples, so six low samples are demanded
	property p_pin_off;
		!transmit_power_enable [*6] |-> transmitter_powered == 12'h000;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin low but powered");
	// Enable write lands one cycle later while the pin is high
	property p_bits;
		transmit_power_enable [*6] ##0 (reg_write && reg_addr == TXE_OFS_TX_ENABLE)
			|=> {20'h0, transmitter_powered} == ($past(reg_wdata) & 32'h0000_0fff);
	endproperty
	a_bits: assert property (p_bits) else $error("power not following bits");
	// Status reads zero while the pin is low
	property p_stat_off;
		!transmit_power_enable [*6] ##0 (reg_read && reg_addr == TXE_OFS_STATUS) |=> reg_rdata == 32'h0;
	endproperty
	a_stat_off: assert property (p_stat_off) else $error("status shows power");
	// Unpowered channel is released on the next cycle
	property p_release;
		1'b1 |=> (line_output_enable_n | $past(transmitter_powered)) == 12'hfff;
	endproperty
	a_release: assert property (p_release) else $error("line not released");
	// Steady power drives exactly the powered channels
	property p_drive;
		(!$past(rst) && !$past(rst, 2) && transmitter_powered == $past(transmitter_powered))
			|-> line_output_enable_n == ~transmitter_powered;
	endproperty
	a_drive: assert property (p_drive) else $error("enable not matching power");
	// Released outputs carry no pulse
	property p_quiet;
		(line_output_enable_n & (line_output_positive | line_output_negative)) == 12'h000;
	endproperty
	a_quiet: assert property (p_quiet) else $error("pulse on released line");
	// Never both polarities in one symbol
	property p_one_pol;
		(line_output_positive & line_output_negative) == 12'h000;
	endproperty
	a_one_pol: assert property (p_one_pol) else $error("both polarities");
	// No transmit clock activity, no new symbol
	property p_own_clk;
		($stable(channel_transmit_clock) && $stable(transmitter_powered)) [*6]
			|-> $stable(line_output_positive) && $stable(line_output_negative);
	endproperty
	a_own_clk: assert property (p_own_clk) else $error("symbol without clock");
	// Read data only stands after a read
	property p_rdata;
		!$past(reg_read) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("stray read data");
endmodule : txe_input_properties

bind txe_tx_input_encoder txe_input_properties u_txe_input_properties (.clock, .rst, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .transmit_power_enable, .channel_transmit_clock, .line_output_positive,
	.line_output_negative, .line_output_enable_n, .transmitter_powered);
`default_nettype wire

// >>> sim/txe_framer_model.sv
`default_nettype none
module txe_framer_model (
	input wire logic clock,
	output logic [11:0] channel_transmit_clock,
	output logic [11:0] transmit_positive_data,
	output logic [11:0] transmit_negative_data,
	output logic sample_now
);
	timeunit 1ns;
	timeprecision 1ps;
	import txe_pkg::*;
	// ------------------------------------------------------------
	// Pattern store and idle state
	// ------------------------------------------------------------
	logic [63:0] pos_pat [12];
	logic [63:0] neg_pat [12];
	// Clocks stand low outside frames; negative rail starts low
	initial begin
		channel_transmit_clock = 12'h000;
		transmit_positive_data = 12'h000;
		transmit_negative_data = 12'h000;
		sample_now = 1'b0;
		for (int c = 0; c < 12; c++) begin
			pos_pat[c] = 64'h0;
			neg_pat[c] = 64'h0;
		end
	end
	// One symbol every ten system cycles: a scaled rate, since the
	// receiving side cannot follow more than a quarter of its clock
	task automatic run(input logic [11:0] mask, input logic [11:0] dual, input int nsym);
		for (int k = 0; k < nsym; k++) begin
			@(posedge clock);
			sample_now <= 1'b0;
			for (int c = 0; c < 12; c++) begin
				if (mask[c]) begin
					transmit_positive_data[c] <= pos_pat[c][k];
					transmit_negative_data[c] <= neg_pat[c][k];
				end
			end
			repeat (4) @(posedge clock);
			channel_transmit_clock <= channel_transmit_clock | mask;
			repeat (4) @(posedge clock);
			channel_transmit_clock <= channel_transmit_clock & ~mask;
			@(posedge clock);
			sample_now <= 1'b1;
		end
		// Released positive rails, and negative rails of dual-rail channels, no longer show the last value
		@(posedge clock);
		sample_now <= 1'b0;
		transmit_positive_data <= transmit_positive_data ^ mask;
		transmit_negative_data <= transmit_negative_data ^ (mask & dual);
	endtask : run
endmodule : txe_framer_model
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import txe_pkg::*;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic clock, rst, clock_enable, reg_write, reg_read, transmit_power_enable, sample_now;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rdv;
	logic [11:0] channel_transmit_clock, transmit_positive_data, transmit_negative_data;
	logic [11:0] line_output_positive, line_output_negative, line_output_enable_n, transmitter_powered;
	logic [1:0] cap [12][64];
	int error_cnt = 0;
	int comparisons = 0;
	int ncap = 0;
	localparam logic [63:0] SR = 64'h8c21_0003_0401_0081;
	localparam logic [63:0] DP = 64'h9249_2492_4924_9249;
	localparam logic [63:0] DN = 64'h2492_4924_9249_2492;
	txe_tx_input_encoder u_txe_tx_input_encoder (.clock(clock), .rst(rst), .clock_enable(clock_enable),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .transmit_power_enable(transmit_power_enable),
		.channel_transmit_clock(channel_transmit_clock), .transmit_positive_data(transmit_positive_data),
		.transmit_negative_data(transmit_negative_data), .line_output_positive(line_output_positive),
		.line_output_negative(line_output_negative), .line_output_enable_n(line_output_enable_n),
		.transmitter_powered(transmitter_powered));
	txe_framer_model u_txe_framer_model (.clock(clock), .channel_transmit_clock(channel_transmit_clock),
		.transmit_positive_data(transmit_positive_data), .transmit_negative_data(transmit_negative_data),
		.sample_now(sample_now));
	// Clock
	initial clock = 1'b0;
	always #5 clock = ~clock;
	// Line symbols taken once per symbol, two cycles after each transmit clock fall
	always @(posedge clock) begin
		if (sample_now === 1'b1) begin
			for (int c = 0; c < 12; c++) cap[c][ncap] <= {line_output_positive[c], line_output_negative[c]};
			ncap <= ncap + 1;
		end
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	// Reference line coder; zl is the zero run that gets replaced
	task automatic encode(input logic [63:0] b, input int zl, output logic [1:0] e [64]);
		logic pol;
		int par, z;
		pol = 1'b0;
		par = 0;
		z = 0;
		for (int i = 0; i < 64; i++) begin
			e[i] = 2'b00;
			if (b[i]) begin
				pol = ~pol;
				e[i] = {pol, ~pol};
				par ^= 1;
				z = 0;
			end else begin
				z = z + 1;
				if (z == zl) begin
					if (par == 0) begin
						pol = ~pol;
						e[i - zl + 1] = {pol, ~pol};
					end
					e[i] = {pol, ~pol};
					par = 0;
					z = 0;
				end
			end
		end
	endtask : encode
	// Latency is aligned on the first pulse, then 48 symbols compared
	task automatic chk_chan(input int c, input logic [63:0] p, input logic [63:0] n, input logic dual, input int zl);
		logic [1:0] e [64];
		int j;
		if (dual) for (int i = 0; i < 64; i++) e[i] = {p[i], n[i]};
		else encode(p, zl, e);
		j = 0;
		while (j < 12 && cap[c][j] === 2'b00) j++;
		for (int i = 0; i < 48; i++) chk({30'h0, cap[c][j + i]}, {30'h0, e[i]}, "line symbol");
	endtask : chk_chan
	task automatic wrap_up;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// Hang guard
	initial begin
		repeat (20000) @(posedge clock);
		$display("BAD %0t watchdog expired", $time);
		error_cnt++;
		wrap_up;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		clock_enable = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		transmit_power_enable = 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rd(TXE_OFS_TX_ENABLE, rdv);
		chk(rdv, 32'h0000_0fff, "enable reset");
		rd(TXE_OFS_STATUS, rdv);
		chk(rdv, 32'h0000_1fff, "status reset");
		rd(8'h40, rdv);
		chk(rdv, 32'h0, "unmapped read");
		$display("test reset_values done");
		// Ch0 and ch4 dual rail; ch1 DS3, ch2 E3, ch3 STS-1
		wr(TXE_OFS_RAIL_MODE, 32'h0000_0011);
		wr(TXE_OFS_RATE_SEL, 32'h0000_0090);
		wr(TXE_OFS_MON_SEL, 32'h0);
		rd(TXE_OFS_RATE_SEL, rdv);
		chk(rdv, 32'h0000_0090, "rate readback");
		wr(TXE_OFS_PRBS_EN, 32'h0000_0800);
		rd(TXE_OFS_PRBS_EN, rdv);
		chk(rdv, 32'h0000_0800, "prbs enable readback");
		u_txe_framer_model.pos_pat[0] = DP;
		u_txe_framer_model.neg_pat[0] = DN;
		for (int c = 1; c < 4; c++) u_txe_framer_model.pos_pat[c] = SR;
		// Noisy negative rail on a single-rail channel must be ignored
		u_txe_framer_model.neg_pat[1] = 64'hffff_ffff_ffff_ffff;
		u_txe_framer_model.run(12'h00f, 12'h011, 64);
		chk_chan(0, DP, DN, 1'b1, 0);
		chk_chan(1, SR, 64'h0, 1'b0, 3);
		chk_chan(2, SR, 64'h0, 1'b0, 4);
		chk_chan(3, SR, 64'h0, 1'b0, 3);
		for (int k = 0; k < 64; k++) chk({28'h0, cap[4][k], cap[5][k]}, 32'h0, "unclocked channel");
		$display("test line_streams done");
		// Monitor buffer overflowed during the frame; drain it
		rd(TXE_OFS_DROP_CNT, rdv);
		// 64 symbols offered, the buffer keeps exactly its depth
		chk(rdv, 32'(64 - TXE_FIFO_D), "drop count");
		for (int i = 0; i < 8; i++) begin
			rd(TXE_OFS_MON_DATA, rdv);
			chk(rdv, {1'b1, 29'h0, DP[i], DN[i]}, "monitor word");
		end
		rd(TXE_OFS_MON_DATA, rdv);
		chk(rdv, 32'h0, "monitor empty");
		$display("test monitor_buffer done");
		// Per-channel bits, then the global pin
		wr(TXE_OFS_TX_ENABLE, 32'h0000_00a5);
		repeat (2) @(posedge clock);
		#1;
		chk({20'h0, transmitter_powered}, 32'h0a5, "powered by bits");
		chk({20'h0, line_output_enable_n}, 32'hf5a, "release by bit");
		@(posedge clock);
		transmit_power_enable <= 1'b0;
		repeat (8) @(posedge clock);
		#1;
		chk({20'h0, transmitter_powered}, 32'h0, "pin low power");
		chk({20'h0, line_output_enable_n}, 32'hfff, "pin low release");
		rd(TXE_OFS_STATUS, rdv);
		chk(rdv, 32'h0, "pin low status");
		@(posedge clock);
		transmit_power_enable <= 1'b1;
		repeat (8) @(posedge clock);
		rd(TXE_OFS_STATUS, rdv);
		chk(rdv, 32'h0000_10a5, "pin high status");
		$display("test power_control done");
		// Second reset in mid-run
		@(posedge clock);
		rst <= 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rd(TXE_OFS_STATUS, rdv);
		chk(rdv, 32'h0000_1fff, "status after second reset");
		$display("test second_reset done");
		wrap_up;
	end
endmodule : tb_top
`default_nettype wire
